// [rtl/iapc_top.sv]
/*
 iapc_top: receives nine-byte command frames, checks them, and executes the
 three indexed axis parameter and three indexed user variable commands.
 assumes the axis parameter table outside reads combinationally while the
 read strobe is high, and that the host waits for a reply before sending more.
*/
// Contract
// RULE_01: opcode 16 writes value into parameter type of the indexed axis.
// RULE_02: opcode 17 reads parameter type of indexed axis into accumulator.
// RULE_03: direct parameter read replies status 100 with the value read.
// RULE_04: opcode 18 writes accumulator into parameter type of indexed axis.
// RULE_05: parameter read takes the axis from the index, never the bank field.
// RULE_06: set indexed variable stores the immediate value at the indexed slot.
// RULE_07: variable commands do nothing when index lies outside 0 to 255.
// RULE_08: opcode 0x38 loads the accumulator from the indexed user variable.
// RULE_09: opcode 0x39 stores the accumulator into the indexed user variable.
// RULE_10: every executed direct command replies status 100.
// RULE_11: frame is address, opcode, type, bank, value msb first, checksum.
// RULE_12: checksum is the byte sum of eight bytes; mismatching frames rejected.
// RULE_13: the index register is loaded with a valid number beforehand.
`timescale 1ns/1ps
module iapc_top (
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   input wire logic [7:0] rx_byte_in,
   input wire logic rx_valid_in,
   input wire logic prog_valid_in,
   input wire iapc_pkg::iapc_cmd_t prog_cmd_in,
   input wire logic [31:0] index_in,
   input wire logic [31:0] accu_in,
   input wire logic [31:0] param_rdata_in,
   output iapc_pkg::iapc_param_req_t param_out,
   output logic accu_wr_out,
   output logic [31:0] accu_data_out,
   output logic reply_valid_out,
   output iapc_pkg::iapc_reply_t reply_out,
   output logic busy_out
);
   // reset synchroniser stages
   logic rst_s1_reg;
   logic rst_b_reg;
   // frame receiver state
   logic [3:0] cnt_reg, cnt_next;
   logic [7:0] sum_reg, sum_next;
   logic [63:0] frame_reg, frame_next;
   logic done_reg, done_next;
   logic sum_ok_reg, sum_ok_next;
   // command control state
   iapc_pkg::iapc_state_t state_reg, state_next;
   iapc_pkg::iapc_cmd_t cmd_reg, cmd_next;
   logic direct_reg, direct_next;
   logic cmd_ok_reg, cmd_ok_next;
   logic [7:0] status_reg, status_next;
   logic [31:0] rval_reg, rval_next;
   iapc_pkg::iapc_param_req_t param_reg, param_next;
   logic accu_wr_reg, accu_wr_next;
   logic [31:0] accu_data_reg, accu_data_next;
   logic reply_valid_reg, reply_valid_next;
   iapc_pkg::iapc_reply_t reply_reg, reply_next;
   logic busy_reg, busy_next;
   // user variable array with its single write port
   logic [31:0] var_reg [iapc_pkg::VAR_COUNT];
   logic [31:0] var_next [iapc_pkg::VAR_COUNT];
   logic var_we;
   logic [7:0] var_idx;
   logic [31:0] var_wdata;
   // decoded helpers
   logic idx_ok;
   logic frame_hit;
   logic op_known;

   // all checks below live in the synchronised clock and reset domain
   default clocking chk_cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_b_reg);

   // reset is applied at once and released through two stages
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rst_s1_reg <= 1'b0;
         rst_b_reg <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_b_reg <= rst_s1_reg;
      end
   end

   // byte collector: eight bytes are shifted in, the ninth is the checksum
   always_comb begin
      cnt_next = cnt_reg;
      sum_next = sum_reg;
      frame_next = frame_reg;
      done_next = 1'b0;
      sum_ok_next = sum_ok_reg;
      if (rx_valid_in) begin
         if (cnt_reg == iapc_pkg::LAST_BYTE_IDX) begin
            cnt_next = 4'h0;
            sum_next = 8'h00;
            done_next = 1'b1;
            sum_ok_next = (rx_byte_in == sum_reg); // see RULE_12
         end else begin
            cnt_next = cnt_reg + 4'h1;
            sum_next = sum_reg + rx_byte_in; // modulo 256 by width, see RULE_12
            frame_next = {frame_reg[55:0], rx_byte_in}; // first byte ends on top, see RULE_11
         end
      end
   end

   // byte collector registers
   always_ff @(posedge ref_clk_in or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         cnt_reg <= 4'h0;
         sum_reg <= 8'h00;
         frame_reg <= 64'h0000000000000000;
         done_reg <= 1'b0;
         sum_ok_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         sum_reg <= sum_next;
         frame_reg <= frame_next;
         done_reg <= done_next;
         sum_ok_reg <= sum_ok_next;
      end
   end

   // a finished frame for this module; other addresses get no answer
   assign frame_hit = done_reg &&
      (frame_reg[iapc_pkg::ADDR_MSB -: 8] == iapc_pkg::MODULE_ADDR);
   // negative or too large indices have bits above the low byte set
   assign idx_ok = (index_in[31:8] == 24'h000000); // see RULE_07
   // opcodes this block executes
   assign op_known = cmd_reg.opcode inside {iapc_pkg::OP_SET_AXIS_PARAM_INDEXED,
      iapc_pkg::OP_GET_AXIS_PARAM_INDEXED, iapc_pkg::OP_ACCU_TO_AXIS_PARAM_INDEXED,
      iapc_pkg::OP_SET_USER_VAR_INDEXED, iapc_pkg::OP_GET_USER_VAR_INDEXED,
      iapc_pkg::OP_ACCU_TO_USER_VAR_INDEXED};

   // command sequencer: take, execute, wait for a parameter read, reply
   always_comb begin
      state_next = state_reg;
      cmd_next = cmd_reg;
      direct_next = direct_reg;
      cmd_ok_next = cmd_ok_reg;
      status_next = status_reg;
      rval_next = rval_reg;
      param_next = param_reg;
      accu_wr_next = 1'b0;
      accu_data_next = accu_data_reg;
      reply_valid_next = 1'b0;
      reply_next = reply_reg;
      var_we = 1'b0;
      var_idx = index_in[7:0];
      var_wdata = cmd_reg.value;
      unique case (state_reg)
         iapc_pkg::ST_IDLE: begin
            if (frame_hit) begin
               cmd_next.opcode = frame_reg[iapc_pkg::OPCODE_MSB -: 8]; // see RULE_11
               cmd_next.ptype = frame_reg[iapc_pkg::TYPE_MSB -: 8];
               cmd_next.bank = frame_reg[iapc_pkg::BANK_MSB -: 8];
               cmd_next.value = frame_reg[iapc_pkg::VALUE_MSB -: 32];
               direct_next = 1'b1;
               cmd_ok_next = sum_ok_reg;
               state_next = iapc_pkg::ST_EXEC;
            end else if (prog_valid_in) begin
               cmd_next = prog_cmd_in; // stored program: no checksum, no reply
               direct_next = 1'b0;
               cmd_ok_next = 1'b1;
               state_next = iapc_pkg::ST_EXEC;
            end
         end
         iapc_pkg::ST_EXEC: begin
            state_next = iapc_pkg::ST_WAIT;
            status_next = iapc_pkg::STATUS_OK;
            rval_next = 32'h00000000; // reply value is a don't care but for a read
            if (!cmd_ok_reg) begin
               status_next = iapc_pkg::STATUS_BAD_CHECKSUM; // nothing runs, see RULE_12
            end else begin
               unique case (cmd_reg.opcode)
                  iapc_pkg::OP_SET_AXIS_PARAM_INDEXED: begin
                     param_next.wr = 1'b1; // see RULE_01
                     param_next.axis = index_in[7:0]; // bank field ignored
                     param_next.num = cmd_reg.ptype;
                     param_next.wdata = cmd_reg.value;
                  end
                  iapc_pkg::OP_GET_AXIS_PARAM_INDEXED: begin
                     param_next.rd = 1'b1; // see RULE_02
                     param_next.axis = index_in[7:0]; // never the bank, see RULE_05
                     param_next.num = cmd_reg.ptype;
                  end
                  iapc_pkg::OP_ACCU_TO_AXIS_PARAM_INDEXED: begin
                     param_next.wr = 1'b1; // see RULE_04
                     param_next.axis = index_in[7:0];
                     param_next.num = cmd_reg.ptype;
                     param_next.wdata = accu_in; // value field ignored
                  end
                  iapc_pkg::OP_SET_USER_VAR_INDEXED: begin
                     var_we = idx_ok; // see RULE_06 RULE_07
                     var_wdata = cmd_reg.value;
                  end
                  iapc_pkg::OP_GET_USER_VAR_INDEXED: begin
                     if (idx_ok) begin
                        accu_wr_next = 1'b1; // see RULE_08 RULE_07
                        accu_data_next = var_reg[index_in[7:0]];
                     end
                  end
                  iapc_pkg::OP_ACCU_TO_USER_VAR_INDEXED: begin
                     var_we = idx_ok; // see RULE_09 RULE_07
                     var_wdata = accu_in;
                  end
                  default: begin
                     status_next = iapc_pkg::STATUS_BAD_OPCODE;
                  end
               endcase
            end
         end
         iapc_pkg::ST_WAIT: begin
            // the parameter table answers while the read strobe stands
            param_next.wr = 1'b0;
            param_next.rd = 1'b0;
            if (param_reg.rd) begin
               accu_wr_next = 1'b1; // see RULE_02
               accu_data_next = param_rdata_in;
               rval_next = param_rdata_in; // see RULE_03
            end
            state_next = iapc_pkg::ST_REPLY;
         end
         iapc_pkg::ST_REPLY: begin
            reply_valid_next = direct_reg; // see RULE_10
            reply_next.status = status_reg;
            reply_next.opcode = cmd_reg.opcode;
            reply_next.value = rval_reg;
            state_next = iapc_pkg::ST_IDLE;
         end
      endcase
      busy_next = (state_next != iapc_pkg::ST_IDLE);
   end

   // command sequencer registers
   always_ff @(posedge ref_clk_in or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         state_reg <= iapc_pkg::ST_IDLE;
         cmd_reg <= '0;
         direct_reg <= 1'b0;
         cmd_ok_reg <= 1'b0;
         status_reg <= 8'h00;
         rval_reg <= 32'h00000000;
         param_reg <= '0;
         accu_wr_reg <= 1'b0;
         accu_data_reg <= 32'h00000000;
         reply_valid_reg <= 1'b0;
         reply_reg <= '0;
         busy_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cmd_reg <= cmd_next;
         direct_reg <= direct_next;
         cmd_ok_reg <= cmd_ok_next;
         status_reg <= status_next;
         rval_reg <= rval_next;
         param_reg <= param_next;
         accu_wr_reg <= accu_wr_next;
         accu_data_reg <= accu_data_next;
         reply_valid_reg <= reply_valid_next;
         reply_reg <= reply_next;
         busy_reg <= busy_next;
      end
   end

   // one user variable per entry, written only when its index is chosen
   for (genvar e = 0; e < iapc_pkg::VAR_COUNT; e++) begin : g_var
      always_comb begin
         var_next[e] = var_reg[e];
         if (var_we && (var_idx == 8'(e))) begin
            var_next[e] = var_wdata; // see RULE_06 RULE_09
         end
      end
      always_ff @(posedge ref_clk_in or negedge rst_b_reg) begin
         if (!rst_b_reg) begin
            var_reg[e] <= 32'h00000000;
         end else begin
            var_reg[e] <= var_next[e];
         end
      end
   end

   // outputs come straight from their registers
   assign param_out = param_reg;
   assign accu_wr_out = accu_wr_reg;
   assign accu_data_out = accu_data_reg;
   assign reply_valid_out = reply_valid_reg;
   assign reply_out = reply_reg;
   assign busy_out = busy_reg;

   // a command in execution with a good checksum, by opcode
   sequence exec_op_s(logic [7:0] op);
      state_reg == iapc_pkg::ST_EXEC && cmd_ok_reg && cmd_reg.opcode == op;
   endsequence
   // a direct command with a good checksum and a known opcode in execution
   sequence exec_direct_s;
      state_reg == iapc_pkg::ST_EXEC && direct_reg && cmd_ok_reg && op_known;
   endsequence
   // the success reply on the link
   sequence reply_ok_s;
      reply_valid_reg && reply_reg.status == iapc_pkg::STATUS_OK;
   endsequence

   axis_set_a: assert property ( // see RULE_01
      exec_op_s(iapc_pkg::OP_SET_AXIS_PARAM_INDEXED) |=> param_reg.wr &&
      param_reg.axis == $past(index_in[7:0]) && param_reg.num == $past(cmd_reg.ptype) &&
      param_reg.wdata == $past(cmd_reg.value))
      else $error("indexed parameter write lost axis, number or value");
   axis_get_a: assert property ( // see RULE_02 RULE_05
      exec_op_s(iapc_pkg::OP_GET_AXIS_PARAM_INDEXED) |=> param_reg.rd &&
      param_reg.axis == $past(index_in[7:0]) && param_reg.num == $past(cmd_reg.ptype))
      else $error("indexed parameter read not aimed at the indexed axis");
   get_reply_a: assert property ( // see RULE_03
      exec_op_s(iapc_pkg::OP_GET_AXIS_PARAM_INDEXED) ##0 direct_reg |->
      ##3 reply_reg.value == $past(param_rdata_in, 2))
      else $error("parameter read reply does not carry the value read");
   axis_accu_a: assert property ( // see RULE_04
      exec_op_s(iapc_pkg::OP_ACCU_TO_AXIS_PARAM_INDEXED) |=> param_reg.wr &&
      param_reg.axis == $past(index_in[7:0]) && param_reg.wdata == $past(accu_in))
      else $error("accumulator not written to the indexed axis parameter");
   var_set_a: assert property ( // see RULE_06
      exec_op_s(iapc_pkg::OP_SET_USER_VAR_INDEXED) ##0 idx_ok |=>
      var_reg[$past(index_in[7:0])] == $past(cmd_reg.value))
      else $error("immediate value not stored in the indexed variable");
   var_range_a: assert property ( // see RULE_07
      state_reg == iapc_pkg::ST_EXEC && !idx_ok |-> !var_we ##1 !accu_wr_reg)
      else $error("variable touched with an index out of range");
   var_get_a: assert property ( // see RULE_08
      exec_op_s(iapc_pkg::OP_GET_USER_VAR_INDEXED) ##0 idx_ok |=> accu_wr_reg &&
      accu_data_reg == $past(var_reg[index_in[7:0]]))
      else $error("accumulator not loaded from the indexed variable");
   var_accu_a: assert property ( // see RULE_09
      exec_op_s(iapc_pkg::OP_ACCU_TO_USER_VAR_INDEXED) ##0 idx_ok |=>
      var_reg[$past(index_in[7:0])] == $past(accu_in))
      else $error("accumulator not stored in the indexed variable");
   reply_ok_a: assert property ( // see RULE_10
      exec_direct_s |-> ##3 reply_ok_s)
      else $error("executed direct command gave no success reply");
   bad_sum_a: assert property ( // see RULE_12
      state_reg == iapc_pkg::ST_EXEC && direct_reg && !cmd_ok_reg |=>
      !param_reg.wr && !param_reg.rd ##2 reply_valid_reg &&
      reply_reg.status == iapc_pkg::STATUS_BAD_CHECKSUM)
      else $error("frame with a bad checksum was not rejected");
endmodule

// [rtl/iapc_pkg.sv]
/*
 iapc_pkg: opcodes, status codes, frame layout and carrier types for the
 indexed axis parameter and indexed user variable command block.
 assumes nothing of its surroundings; imported by name only.
*/
package iapc_pkg;
   // opcodes handled by this block
   localparam logic [7:0] OP_SET_AXIS_PARAM_INDEXED = 8'h10;
   localparam logic [7:0] OP_GET_AXIS_PARAM_INDEXED = 8'h11;
   localparam logic [7:0] OP_ACCU_TO_AXIS_PARAM_INDEXED = 8'h12;
   localparam logic [7:0] OP_SET_USER_VAR_INDEXED = 8'h37;
   localparam logic [7:0] OP_GET_USER_VAR_INDEXED = 8'h38;
   localparam logic [7:0] OP_ACCU_TO_USER_VAR_INDEXED = 8'h39;
   // reply status codes
   localparam logic [7:0] STATUS_OK = 8'h64;
   localparam logic [7:0] STATUS_BAD_CHECKSUM = 8'h01;
   localparam logic [7:0] STATUS_BAD_OPCODE = 8'h02;
   // frame target address this module answers to
   localparam logic [7:0] MODULE_ADDR = 8'h01;
   // index of the checksum byte, the ninth byte of a frame
   localparam logic [3:0] LAST_BYTE_IDX = 4'h8;
   // field positions within the eight collected bytes
   localparam int ADDR_MSB = 63;
   localparam int OPCODE_MSB = 55;
   localparam int TYPE_MSB = 47;
   localparam int BANK_MSB = 39;
   localparam int VALUE_MSB = 31;
   // user variable array
   localparam int VAR_COUNT = 256;
   localparam int VAR_IDX_W = 8;

   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] ptype;
      logic [7:0] bank;
      logic [31:0] value;
   } iapc_cmd_t;

   typedef struct packed {
      logic [7:0] status;
      logic [7:0] opcode;
      logic [31:0] value;
   } iapc_reply_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] axis;
      logic [7:0] num;
      logic [31:0] wdata;
   } iapc_param_req_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EXEC = 2'b01,
      ST_WAIT = 2'b11,
      ST_REPLY = 2'b10
   } iapc_state_t;
endpackage

// [tb/iapc_host.sv]
/* iapc_host: host frame sender; assumes one byte taken a cycle */
`timescale 1ns/1ps
module iapc_host (input wire logic clk_in, output logic [7:0] b_out, output logic v_out);
   initial {v_out, b_out} = 9'h000;
   // bytes msb first, sum last
   // bad flips the low checksum bit to make a corrupt frame
   task automatic send(input logic [63:0] f, input logic bad);
      logic [7:0] s = 8'h00;
      for (int i = 8; i >= 0; i--) begin
         @(negedge clk_in) {v_out, b_out} = {1'b1, i > 0 ? f[i*8-8+:8] : s ^ {7'h00, bad}};
         s += b_out;
      end
      @(negedge clk_in) {v_out, b_out} = {1'b0, ~s};
   endtask
endmodule

// [tb/iapc_top_tb.sv]
/* iapc_top_tb: indexed commands; assumes reply in 40 cycles */
`timescale 1ns/1ps
module iapc_top_tb;
   logic clk = 1'b0, rst_b = 1'b0, rv, aw, rpv;
   logic [7:0] rb, st;
   logic [31:0] lf = 32'h6B35F753, k = 32'h0, ad, v, rval;
   int err_count = 0, total_checks = 0, cyc = 0;
   iapc_pkg::iapc_reply_t rep;
   iapc_pkg::iapc_param_req_t pr, pq;
   always #4 clk = ~clk;
   iapc_host iapc_host_inst (.clk_in(clk), .b_out(rb), .v_out(rv));
   iapc_top iapc_top_inst (.ref_clk_in(clk), .rst_b_in(rst_b), .rx_byte_in(rb),
      .rx_valid_in(rv), .prog_valid_in(1'b0), .prog_cmd_in('0), .index_in(k),
      .accu_in(~lf), .param_rdata_in(lf), .param_out(pr), .accu_wr_out(aw),
      .accu_data_out(ad), .reply_valid_out(rpv), .reply_out(rep), .busy_out());
   always @(posedge clk) {v, st} <= {aw === 1'b1 ? ad : v, rpv === 1'b1 ? rep.status : st};
   always @(posedge clk) rval <= rpv === 1'b1 ? rep.value : rval;
   always @(posedge clk) pq <= (pr.wr | pr.rd) === 1'b1 ? pr : pq;
   always @(posedge clk) if (++cyc > 6000) results(1);
   // next random word
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], ^(s & 32'h80200003)};
   endfunction
   task automatic run(input logic [7:0] op, input logic [7:0] ty, input logic bad);
      iapc_host_inst.send({iapc_pkg::MODULE_ADDR, op, ty, 8'hA5, lf}, bad);
      repeat (40) @(negedge clk);
   endtask
   task automatic chk(input logic g);
      total_checks++;
      if (!g) begin
         err_count++;
         $display("BAD %0t check failed, accu %0h", $time, v);
      end
   endtask
   task automatic results(input int t);
      $display("%0d bad of %0d", err_count + t, total_checks);
      if (err_count + t == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #16 rst_b = 1'b1;
      repeat (2) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
         lf = lfsr(lf);
         k = i ? lf & 32'hFF : 32'hFF;
         run(8'h37, 8'h00, 1'b0);
         run(8'h38, 8'h00, 1'b0);
         chk(v === lf && st === 8'h64);
         run(8'h39, 8'h00, 1'b0);
         k ^= {i[0], 22'h0, ~i[0], 8'h0};
         run(8'h37, 8'h00, 1'b0);
         k ^= {i[0], 22'h0, ~i[0], 8'h0};
         run(8'h38, 8'h00, 1'b0);
         chk(v === ~lf);
         run(8'h10, lf[7:0], 1'b0);
         chk(pq.wr === 1'b1 && pq.axis === k[7:0] && pq.num === lf[7:0] && pq.wdata === lf);
         run(8'h11, lf[15:8], 1'b0);
         chk(v === lf && rval === lf && st === 8'h64);
         chk(pq.rd === 1'b1 && pq.axis === k[7:0] && pq.num === lf[15:8]);
         run(8'h12, lf[23:16], 1'b0);
         chk(pq.wr === 1'b1 && pq.wdata === ~lf && pq.num === lf[23:16]);
         run(8'h37, 8'h00, 1'b1);
         chk(st === iapc_pkg::STATUS_BAD_CHECKSUM);
      end
      results(0);
   end
endmodule
